// ==== design/uli_baud.sv ====
`default_nettype none
module uli_baud
  import uli_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  output logic tick_o
);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic tick_next;
  always_comb begin
    cnt_next = cnt_reg + 8'h01;
    tick_next = 1'b0;
    if (!run_i) begin
      cnt_next = 8'h00;
    end else if (cnt_reg == 8'(ULI_BAUD_DIV - 1)) begin
      cnt_next = 8'h00;
      tick_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      tick_o <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_o <= tick_next;
    end
  end
endmodule
`default_nettype wire

// ==== design/uli_pkg.sv ====
`default_nettype none
package uli_pkg;
  // Register byte offsets
  localparam logic [7:0] ULI_CTRL_OFS = 8'h00;
  localparam logic [7:0] ULI_MODE_OFS = 8'h04;
  localparam logic [7:0] ULI_LIN_ID_OFS = 8'h08;
  localparam logic [7:0] ULI_LINMODE_OFS = 8'h0C;
  localparam logic [7:0] ULI_NERR_OFS = 8'h10;
  localparam logic [7:0] ULI_STAT_OFS = 8'h14;
  localparam logic [7:0] ULI_IMASK_OFS = 8'h18;
  localparam logic [7:0] ULI_RXDATA_OFS = 8'h1C;
  // Control register strobe bits
  localparam int ULI_CTL_RXRST = 0;
  localparam int ULI_CTL_RTS_EN = 1;
  localparam int ULI_CTL_RTS_DIS = 2;
  // Mode register fields
  localparam int ULI_MR_HANDSHAKE = 0;
  localparam int ULI_MR_LIN_MASTER = 1;
  localparam int ULI_MR_ISO_T1 = 2;
  // LIN mode register: dma mode select
  localparam int ULI_LM_DMA_SEL = 0;
  // Status bits
  localparam int ULI_ST_LIN_ID = 0;
  localparam int ULI_ST_RXRDY = 1;
  localparam int ULI_ST_TXDONE = 2;
  localparam int ULI_ST_W = 3;
  // Reset values
  localparam logic [7:0] ULI_MODE_RST = 8'h00;
  localparam logic ULI_LINMODE_RST = 1'b0;
  // Baud: 10 MHz / 16
  localparam int ULI_CLK_HZ = 10_000_000;
  localparam int ULI_BAUD = 625_000;
  localparam int ULI_BAUD_DIV = ULI_CLK_HZ / ULI_BAUD;
  localparam logic [7:0] ULI_SYNC_BYTE = 8'h55;
endpackage
`default_nettype wire

// ==== design/uli_shift.sv ====
`default_nettype none
// One 10-bit frame shifter, serial out
module uli_shift (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic load_i,
  input wire logic [7:0] data_i,
  output logic busy_o,
  output logic txd_o
);
  logic [9:0] sh_reg;
  logic [9:0] sh_next;
  logic [3:0] n_reg;
  logic [3:0] n_next;
  logic txd_next;
  always_comb begin
    sh_next = sh_reg;
    n_next = n_reg;
    txd_next = txd_o;
    if (load_i && n_reg == 4'h0) begin
      sh_next = {1'b1, data_i, 1'b0};
      n_next = 4'hA;
    end else if (tick_i && n_reg != 4'h0) begin
      txd_next = sh_reg[0];
      sh_next = {1'b1, sh_reg[9:1]};
      n_next = n_reg - 4'h1;
    end else if (n_reg == 4'h0) begin
      txd_next = 1'b1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_reg <= 10'h3FF;
      n_reg <= 4'h0;
      txd_o <= 1'b1;
    end else begin
      sh_reg <= sh_next;
      n_reg <= n_next;
      txd_o <= txd_next;
    end
  end
  assign busy_o = (n_reg != 4'h0);
endmodule
`default_nettype wire

// ==== design/uli_top.sv ====
// Decided for this implementation: the register addresses and the Wishbone slave port.
`default_nettype none
// How it works
// - As LIN master with dma mode select zero, a leading identifier in the DMA buffer is not used for the header.
// - A write to the LIN identifier register starts the frame once the DMA can supply data.
// - The identifier flag rises on header reception only, never on own header transmission.
// - A DMA LIN transfer with dma mode select at one never starts.
// - In handshake mode RTS is meant to rise on a full DMA receive buffer, but stays low here.
// - Writing one to the RTS disable command without the RTS enable command drives RTS high in normal mode.
// - Writing one to the RTS enable command drives RTS low again.
// - The ISO error-count register always reads zero.
// - In ISO T=1 mode reception is dead after any transmission until a receiver reset.
module uli_top
  import uli_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // DMA transmit request/data and receive buffer full
  input wire logic dma_tx_valid_i,
  input wire logic [7:0] dma_tx_data_i,
  output logic dma_tx_ready_o,
  input wire logic dma_rx_full_i,
  // Serial pins
  input wire logic rxd_i,
  output logic txd_o,
  output logic rts_o,
  // Interrupt
  output logic irq_o
);
  import uli_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {ULI_IDLE = 2'b00, ULI_SYNC = 2'b01, ULI_ID = 2'b11,
                            ULI_DATA = 2'b10} uli_state_t;

  uli_state_t st_reg, st_next;
  logic [7:0] mode_reg, mode_next;
  logic lm_reg, lm_next;
  logic [7:0] id_reg, id_next;
  logic pend_reg, pend_next;
  // Take pulse is registered; the source steps one cycle late while the shifter is busy
  logic dma_take;
  logic rts_next;
  logic [ULI_ST_W-1:0] stat_reg, stat_next;
  logic [ULI_ST_W-1:0] mask_reg, mask_next;
  logic [7:0] rxd_reg, rxd_next;
  logic rx_dead_reg, rx_dead_next;
  logic ack_next;
  logic [31:0] dat_next;
  logic irq_next;
  logic rx_s1_reg, rx_s2_reg;
  logic [7:0] rxsh_reg, rxsh_next;
  logic [3:0] rxn_reg, rxn_next;
  logic [7:0] rxc_reg, rxc_next;
  logic rx_byte;
  logic tick, busy, load;
  logic [7:0] load_data;
  logic wr, rd;

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign rd = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_s1_reg <= 1'b1;
      rx_s2_reg <= 1'b1;
    end else begin
      rx_s1_reg <= rxd_i;
      rx_s2_reg <= rx_s1_reg;
    end
  end

  uli_baud u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(1'b1),
    .tick_o(tick)
  );

  uli_shift u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .load_i(load),
    .data_i(load_data),
    .busy_o(busy),
    .txd_o(txd_o)
  );

  ////////////////////////////////////////////////////////////////////////
  // Simple receiver, sampled at the baud tick; byte 0x55 then an id byte marks a header
  always_comb begin
    rxsh_next = rxsh_reg;
    rxn_next = rxn_reg;
    rx_byte = 1'b0;
    if (tick) begin
      if (rxn_reg == 4'h0) begin
        if (!rx_s2_reg) rxn_next = 4'h9;
      end else begin
        rxn_next = rxn_reg - 4'h1;
        if (rxn_reg == 4'h1) begin
          rx_byte = rx_s2_reg && !rx_dead_reg;
        end else begin
          rxsh_next = {rx_s2_reg, rxsh_reg[7:1]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit header sequencer
  always_comb begin
    st_next = st_reg;
    load = 1'b0;
    load_data = ULI_SYNC_BYTE;
    dma_take = 1'b0;
    pend_next = pend_reg;
    unique case (st_reg)
      ULI_IDLE: begin
        // Setting one never starts a transfer
        if (pend_reg && mode_reg[ULI_MR_LIN_MASTER] && !lm_reg
            && dma_tx_valid_i) begin
          st_next = ULI_SYNC;
          pend_next = 1'b0;
        end
      end
      ULI_SYNC: begin
        if (!busy) begin
          load = 1'b1;
          st_next = ULI_ID;
        end
      end
      ULI_ID: begin
        if (!busy && !load) begin
          load = 1'b1;
          load_data = id_reg;
          st_next = ULI_DATA;
        end
      end
      ULI_DATA: begin
        if (!busy) begin
          if (dma_tx_valid_i) begin
            load = 1'b1;
            load_data = dma_tx_data_i;
            dma_take = 1'b1;
          end else begin
            st_next = ULI_IDLE;
          end
        end
      end
    endcase
    if (wr && wb_adr_i == ULI_LIN_ID_OFS && wb_sel_i[0]) begin
      pend_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers, status and bus answers
  always_comb begin
    mode_next = mode_reg;
    lm_next = lm_reg;
    id_next = id_reg;
    rts_next = rts_o;
    mask_next = mask_reg;
    rxd_next = rxd_reg;
    rxc_next = rxc_reg;
    rx_dead_next = rx_dead_reg;
    stat_next = stat_reg;
    dat_next = 32'h0000_0000;
    ack_next = wb_cyc_i && wb_stb_i && !wb_ack_o;
    // Handshake-mode full buffer does not raise RTS in this revision
    if (wr) begin
      unique case (wb_adr_i)
        ULI_CTRL_OFS: begin
          if (wb_sel_i[0] && wb_dat_i[ULI_CTL_RXRST]) rx_dead_next = 1'b0;
          if (wb_sel_i[0] && wb_dat_i[ULI_CTL_RTS_DIS]) rts_next = 1'b1;
          if (wb_sel_i[0] && wb_dat_i[ULI_CTL_RTS_EN]) rts_next = 1'b0;
        end
        ULI_MODE_OFS: if (wb_sel_i[0]) mode_next = wb_dat_i[7:0];
        ULI_LIN_ID_OFS: if (wb_sel_i[0]) id_next = wb_dat_i[7:0];
        ULI_LINMODE_OFS: if (wb_sel_i[0]) lm_next = wb_dat_i[ULI_LM_DMA_SEL];
        ULI_STAT_OFS: if (wb_sel_i[0]) stat_next = stat_reg & ~wb_dat_i[ULI_ST_W-1:0];
        ULI_IMASK_OFS: if (wb_sel_i[0]) mask_next = wb_dat_i[ULI_ST_W-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      unique case (wb_adr_i)
        ULI_MODE_OFS: dat_next = {24'h00_0000, mode_reg};
        ULI_LIN_ID_OFS: dat_next = {24'h00_0000, id_reg};
        ULI_LINMODE_OFS: dat_next = {31'h0000_0000, lm_reg};
        ULI_NERR_OFS: dat_next = 32'h0000_0000;
        ULI_STAT_OFS: dat_next = {29'h0000_0000, stat_reg};
        ULI_IMASK_OFS: dat_next = {29'h0000_0000, mask_reg};
        ULI_RXDATA_OFS: dat_next = {24'h00_0000, rxd_reg};
        default: dat_next = 32'h0000_0000;
      endcase
    end
    // Events set after the clear so set wins
    if (mode_reg[ULI_MR_ISO_T1] && load) rx_dead_next = 1'b1;
    if (rx_byte) begin
      rxd_next = rxsh_reg;
      rxc_next = rxsh_reg;
      stat_next[ULI_ST_RXRDY] = 1'b1;
      if (rxc_reg == ULI_SYNC_BYTE) stat_next[ULI_ST_LIN_ID] = 1'b1;
    end
    if (st_reg == ULI_DATA && st_next == ULI_IDLE) stat_next[ULI_ST_TXDONE] = 1'b1;
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= ULI_IDLE;
      mode_reg <= ULI_MODE_RST;
      lm_reg <= ULI_LINMODE_RST;
      id_reg <= 8'h00;
      pend_reg <= 1'b0;
      dma_tx_ready_o <= 1'b0;
      rts_o <= 1'b0;
      stat_reg <= '0;
      mask_reg <= '0;
      rxd_reg <= 8'h00;
      rxc_reg <= 8'h00;
      rx_dead_reg <= 1'b0;
      rxsh_reg <= 8'h00;
      rxn_reg <= 4'h0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      irq_o <= 1'b0;
    end else begin
      st_reg <= st_next;
      mode_reg <= mode_next;
      lm_reg <= lm_next;
      id_reg <= id_next;
      pend_reg <= pend_next;
      dma_tx_ready_o <= dma_take;
      rts_o <= rts_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      rxd_reg <= rxd_next;
      rxc_reg <= rxc_next;
      rx_dead_reg <= rx_dead_next;
      rxsh_reg <= rxsh_next;
      rxn_reg <= rxn_next;
      wb_ack_o <= ack_next;
      wb_dat_o <= dat_next;
      irq_o <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  rts_dis_high_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ULI_CTRL_OFS && wb_sel_i[0] && wb_dat_i[ULI_CTL_RTS_DIS]
     && !wb_dat_i[ULI_CTL_RTS_EN]) |=> rts_o) else $error("rts not high after disable");
  rts_en_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == ULI_CTRL_OFS && wb_sel_i[0] && wb_dat_i[ULI_CTL_RTS_EN]) |=> !rts_o)
    else $error("rts not low after enable");
  rts_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr && wb_adr_i == ULI_CTRL_OFS) |=> $stable(rts_o)) else $error("rts moved alone");
  nerr_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == ULI_NERR_OFS) |=> wb_dat_o == 32'h0000_0000)
    else $error("error count not zero");
  ctrl_rd_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rd && wb_adr_i == ULI_CTRL_OFS) |=> wb_dat_o == 32'h0000_0000)
    else $error("control reads nonzero");
  dma_sel_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == ULI_IDLE && lm_reg) |=> st_reg == ULI_IDLE) else $error("dma sel one started");
  start_on_id_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == ULI_IDLE && pend_reg && mode_reg[ULI_MR_LIN_MASTER] && !lm_reg && dma_tx_valid_i)
    |=> st_reg == ULI_SYNC) else $error("frame did not start");
  id_from_reg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg == ULI_ID && load) |-> (load_data == id_reg && !dma_take))
    else $error("header id not from register");
  id_flag_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_reg != ULI_IDLE && !rx_byte) |=> !$rose(stat_reg[ULI_ST_LIN_ID]))
    else $error("id flag on transmit");
  t1_rx_dead_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_reg[ULI_MR_ISO_T1] && load) |=> rx_dead_reg) else $error("t1 rx still alive");
  rx_full_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode_reg[ULI_MR_HANDSHAKE] && dma_rx_full_i && !rts_o
     && !(wr && wb_adr_i == ULI_CTRL_OFS)) |=> !rts_o) else $error("rts rose on full buffer");
  take_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dma_tx_ready_o |=> !dma_tx_ready_o) else $error("dma take longer than one cycle");
  irq_level_a: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o == |(stat_reg & mask_reg)) else $error("irq not level of status");
endmodule
`default_nettype wire

// ==== tb/uli_node.sv ====
`default_nettype none
// Remote LIN slave or card: 8N1 at 16 clocks a bit
module uli_node (
  // Clock
  input wire logic clk_i,
  // Line
  input wire logic txd_i,
  output var logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got[$];
  logic [7:0] sh;
  // Idle line sits high, as a pulled-up bus would
  initial rxd_o = 1'b1;
  // Header source is this sender: 0x55 then the identifier
  task automatic send(input logic [7:0] b);
    rxd_o <= 1'b0;
    repeat (16) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rxd_o <= b[i];
      repeat (16) @(posedge clk_i);
    end
    rxd_o <= 1'b1;
    repeat (16) @(posedge clk_i);
  endtask
  // Resync on every start edge so baud drift never accumulates
  always begin
    @(negedge txd_i);
    repeat (8) @(posedge clk_i);
    if (txd_i == 1'b0) begin
      for (int i = 0; i < 8; i++) begin
        repeat (16) @(posedge clk_i);
        sh[i] = txd_i;
      end
      got.push_back(sh);
      repeat (16) @(posedge clk_i);
    end
  end
endmodule
`default_nettype wire

// ==== tb/uli_top_tb_top.sv ====
`default_nettype none
module uli_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import uli_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, dma_tx_ready_o, txd_o, rts_o, irq_o, rxd;
  logic rx_full = 1'b0;
  logic [7:0] dma_buf[4] = '{8'hA5, 8'h11, 8'h22, 8'h33};
  int dma_n = 0;
  int dma_idx = 0;
  int err_total = 0;
  int compares = 0;
  int cyc_cnt = 0;
  always #50 clk_i = ~clk_i;
  // DMA source advances only on the one-cycle take pulse
  always @(posedge clk_i) if (dma_tx_ready_o) dma_idx <= dma_idx + 1;
  uli_top i_uli_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dma_tx_valid_i(dma_idx < dma_n), .dma_tx_data_i(dma_buf[dma_idx[1:0]]),
    .dma_tx_ready_o(dma_tx_ready_o), .dma_rx_full_i(rx_full), .rxd_i(rxd), .txd_o(txd_o),
    .rts_o(rts_o), .irq_o(irq_o));
  uli_node i_uli_node (.clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // Entered just after a rising edge; leaves one idle cycle behind
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED %0t no bus answer", $time);
    end
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic gap(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic wait_rx(input int n);
    int k;
    k = 0;
    while (i_uli_node.got.size() < n && k < 2000) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 2000) begin
      err_total++;
      $display("CHECK FAILED %0t serial bytes missing", $time);
    end
    gap(20);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({29'h0, txd_o, rts_o, irq_o}, 32'h0000_0004);
    bus(1'b1, ULI_NERR_OFS, 32'h0000_00FF);
    bus(1'b0, ULI_NERR_OFS, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    bus(1'b1, 8'h40, 32'h0000_00FF);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk(rdat, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_rts();
    bus(1'b1, ULI_CTRL_OFS, 32'(1 << ULI_CTL_RTS_DIS));
    chk(32'(rts_o), 32'h0000_0001);
    bus(1'b1, ULI_CTRL_OFS, 32'h0000_0000);
    bus(1'b0, ULI_CTRL_OFS, 32'h0000_0000);
    chk({rdat[31:1], rts_o}, 32'h0000_0001);
    bus(1'b1, ULI_CTRL_OFS, 32'(1 << ULI_CTL_RTS_EN));
    chk(32'(rts_o), 32'h0000_0000);
    bus(1'b1, ULI_MODE_OFS, 32'(1 << ULI_MR_HANDSHAKE));
    rx_full <= 1'b1;
    gap(50);
    chk(32'(rts_o), 32'h0000_0000);
    rx_full <= 1'b0;
    $display("rts test done");
  endtask
  task automatic t_dma_one();
    bus(1'b1, ULI_MODE_OFS, 32'(1 << ULI_MR_LIN_MASTER));
    bus(1'b1, ULI_LINMODE_OFS, 32'(1 << ULI_LM_DMA_SEL));
    dma_idx <= 0;
    dma_n <= 2;
    bus(1'b1, ULI_LIN_ID_OFS, 32'h0000_003C);
    gap(600);
    chk(i_uli_node.got.size() + dma_idx, 32'h0000_0000);
    // A stuck transfer can only be cleared by reset
    dma_n <= 0;
    rst_i <= 1'b1;
    gap(20);
    rst_i <= 1'b0;
    gap(1);
    $display("dma select one test done");
  endtask
  task automatic t_lin_tx();
    bus(1'b1, ULI_MODE_OFS, 32'(1 << ULI_MR_LIN_MASTER));
    bus(1'b1, ULI_LINMODE_OFS, 32'h0000_0000);
    dma_idx <= 0;
    dma_n <= 2;
    gap(100);
    chk(i_uli_node.got.size(), 32'h0000_0000);
    bus(1'b1, ULI_LIN_ID_OFS, 32'h0000_003C);
    wait_rx(4);
    chk(i_uli_node.got.size(), 32'h0000_0004);
    chk({i_uli_node.got[0], i_uli_node.got[1], i_uli_node.got[2], i_uli_node.got[3]},
      {ULI_SYNC_BYTE, 8'h3C, 8'hA5, 8'h11});
    bus(1'b0, ULI_STAT_OFS, 32'h0000_0000);
    chk(32'(rdat[ULI_ST_LIN_ID]), 32'h0000_0000);
    $display("lin transmit test done");
  endtask
  task automatic t_hdr_rx();
    bus(1'b1, ULI_MODE_OFS, 32'h0000_0000);
    i_uli_node.send(ULI_SYNC_BYTE);
    i_uli_node.send(8'h2A);
    gap(20);
    bus(1'b0, ULI_STAT_OFS, 32'h0000_0000);
    chk(32'(rdat[ULI_ST_LIN_ID]), 32'h0000_0001);
    chk(32'(irq_o), 32'h0000_0000);
    bus(1'b1, ULI_IMASK_OFS, 32'(1 << ULI_ST_LIN_ID));
    gap(2);
    chk(32'(irq_o), 32'h0000_0001);
    bus(1'b1, ULI_STAT_OFS, 32'h0000_0007);
    gap(2);
    bus(1'b0, ULI_STAT_OFS, 32'h0000_0000);
    chk({rdat[0], irq_o}, 32'h0000_0000);
    $display("header receive test done");
  endtask
  task automatic t_iso();
    bus(1'b1, ULI_MODE_OFS, 32'(6));
    i_uli_node.send(8'h5A);
    gap(20);
    bus(1'b0, ULI_RXDATA_OFS, 32'h0000_0000);
    chk(rdat & 32'h0000_00FF, 32'h0000_005A);
    bus(1'b1, ULI_STAT_OFS, 32'h0000_0007);
    i_uli_node.got.delete();
    // Frame needs a ready DMA source to start: one data byte behind the header
    dma_idx <= 0;
    dma_n <= 1;
    bus(1'b1, ULI_LIN_ID_OFS, 32'h0000_0033);
    wait_rx(3);
    chk(i_uli_node.got.size(), 32'h0000_0003);
    i_uli_node.send(8'h5A);
    gap(20);
    bus(1'b0, ULI_STAT_OFS, 32'h0000_0000);
    chk(32'(rdat[ULI_ST_RXRDY]), 32'h0000_0000);
    // Recovery: receiver reset, then mode and control rewritten
    bus(1'b1, ULI_CTRL_OFS, 32'(1 << ULI_CTL_RXRST));
    bus(1'b1, ULI_MODE_OFS, 32'(6));
    bus(1'b1, ULI_CTRL_OFS, 32'h0000_0000);
    i_uli_node.send(8'h6B);
    gap(20);
    bus(1'b0, ULI_STAT_OFS, 32'h0000_0000);
    chk(32'(rdat[ULI_ST_RXRDY]), 32'h0000_0001);
    bus(1'b0, ULI_RXDATA_OFS, 32'h0000_0000);
    chk(rdat & 32'h0000_00FF, 32'h0000_006B);
    $display("iso recovery test done");
  endtask
  initial begin
    gap(20);
    rst_i <= 1'b0;
    gap(1);
    t_reset();
    t_rts();
    t_dma_one();
    t_lin_tx();
    t_hdr_rx();
    t_iso();
    conclude();
  end
endmodule
`default_nettype wire
